// *** tb/ccr_host_model.sv ***
// Host computer model: sends commands, collects reply bytes
`timescale 1ns/1ns
`default_nettype none

module ccr_host_model (
  // Clock
  input wire logic clock_in,
  // Command bytes toward the device
  output var ccr_pkg::ccr_byte_s rx_out,
  input wire logic rx_ready_in,
  // Reply bytes from the device
  input wire ccr_pkg::ccr_byte_s tx_in,
  output var logic tx_ready_out,
  // Stall every other cycle when high
  input wire logic slow_in
);
  logic [7:0] got[$];

  initial begin
    rx_out = '0;
    tx_ready_out = 1'b0;
  end

  // ==========================================================
  // Command sender; released data shows the inverse of the last byte
  task automatic send(input string s);
    @(posedge clock_in);
    for (int i = 0; i < s.len(); i++) begin
      rx_out <= '{valid: 1'b1, data: 8'(s[i])};
      @(posedge clock_in);
      while (!rx_ready_in) @(posedge clock_in);
    end
    rx_out <= '{valid: 1'b0, data: ~8'(s[s.len()-1])};
  endtask

  // ==========================================================
  // Receiver with optional stalls
  always @(posedge clock_in) begin
    if (tx_in.valid && tx_ready_out) got.push_back(tx_in.data);
    tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
  end
endmodule // ccr_host_model
`default_nettype wire

// *** tb/ccr_responder_props.sv ***
// Concurrent checks on the responder's ports
`timescale 1ns/1ns
`default_nettype none

module ccr_responder_props #(
  parameter int DARK_W = 32
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Byte link
  input wire ccr_pkg::ccr_byte_s rx_in,
  input wire logic rx_ready_out,
  input wire ccr_pkg::ccr_byte_s tx_out,
  input wire logic tx_ready_in,
  // Switch and calibration
  input wire logic lock_sw_in,
  input wire logic [DARK_W-1:0] dark_meas_in,
  input wire logic dark_cal_start_out,
  input wire logic fw_upgrade_en_out,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  // ==========================================================
  // Cycles since the switch last moved, saturating
  logic [3:0] lock_age;
  logic lock_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lock_age <= 4'hf;
      lock_q <= 1'b0;
    end else begin
      lock_q <= lock_sw_in;
      if (lock_q != lock_sw_in) lock_age <= 4'h0;
      else if (lock_age != 4'hf) lock_age <= lock_age + 4'h1;
    end
  end

  // ==========================================================
  // Properties
  ready_after_x_a: assert property (rx_in.valid && rx_ready_out &&
    rx_in.data == ccr_pkg::CH_X |=> !rx_ready_out)
    else $error("parser kept accepting after terminator");
  tx_hold_a: assert property (tx_out.valid && !tx_ready_in |=>
    tx_out.valid && $stable(tx_out.data))
    else $error("reply byte lost during stall");
  fw_unlocked_a: assert property (!lock_sw_in [*6] |->
    fw_upgrade_en_out) else $error("upgrade not enabled when unlocked");
  fw_locked_a: assert property (lock_sw_in [*6] |->
    !fw_upgrade_en_out) else $error("upgrade enabled when locked");
  start_cause_a: assert property (dark_cal_start_out |->
    (!rx_ready_out || lock_age < 4'h6) ##1 !dark_cal_start_out)
    else $error("calibration start without cause");
  apb_ready_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no answer in first access cycle");
  apb_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("pready held beyond one cycle");
  unmapped_err_a: assert property (psel_in && !penable_in &&
    paddr_in > 8'h10 |=> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel_in && !penable_in &&
    paddr_in[1:0] == 2'b00 && paddr_in <= 8'h10 |=> !pslverr_out)
    else $error("mapped access refused");
endmodule // ccr_responder_props

bind ccr_responder ccr_responder_props #(.DARK_W(DARK_W)) u_props (
  .clock_in(clock_in), .rstn_in(rstn_in), .rx_in(rx_in),
  .rx_ready_out(rx_ready_out), .tx_out(tx_out), .tx_ready_in(tx_ready_in),
  .lock_sw_in(lock_sw_in), .dark_meas_in(dark_meas_in),
  .dark_cal_start_out(dark_cal_start_out),
  .fw_upgrade_en_out(fw_upgrade_en_out), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out));
`default_nettype wire

// *** tb/ccr_responder_tb.sv ***
// Self-checking testbench of the calibration command responder
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED %0t %h %h", $time, (a), (b)); end end

module ccr_responder_tb;
  localparam logic [31:0] P_PROTO = 32'h00000007; // Arbitrary value
  localparam logic [31:0] P_MODEL = 32'h00000042; // Arbitrary value
  localparam logic [31:0] P_FEAT = 32'h00000009; // Arbitrary value
  localparam logic [31:0] P_SER = 32'h00001234; // Arbitrary value
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  ccr_pkg::ccr_byte_s rx, tx;
  logic rx_ready, tx_ready, lock_sw = 1'b0, slow = 1'b0;
  logic [31:0] meas = 32'h0000abcd, rd;
  logic start, fw, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, er;
  int err_count = 0;
  int n_checks = 0;
  int starts = 0;

  always #5 clock_in = ~clock_in;

  ccr_responder #(.PROTO_REV(P_PROTO), .MODEL_CODE(P_MODEL),
    .FEATURE_REV(P_FEAT), .SERIAL_RST(P_SER), .DARK_W(32)) uut (
    .clock_in(clock_in), .rstn_in(rstn_in), .rx_in(rx),
    .rx_ready_out(rx_ready), .tx_out(tx), .tx_ready_in(tx_ready),
    .lock_sw_in(lock_sw), .dark_meas_in(meas), .dark_cal_start_out(start),
    .fw_upgrade_en_out(fw), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));

  ccr_host_model host (.clock_in(clock_in), .rx_out(rx),
    .rx_ready_in(rx_ready), .tx_in(tx), .tx_ready_out(tx_ready),
    .slow_in(slow));

  always @(posedge clock_in) if (start === 1'b1) starts++;

  // ==========================================================
  // APB master and reply checker
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask

  task automatic expect_reply(input string s);
    for (int k = 0; k < 400 && host.got.size() < s.len() + 2; k++)
      @(posedge clock_in);
    `CHK(host.got.size(), s.len() + 2)
    for (int i = 0; i < s.len(); i++) `CHK(host.got[i], 8'(s[i]))
    `CHK(host.got[s.len()], ccr_pkg::CH_CR)
    `CHK(host.got[s.len()+1], ccr_pkg::CH_LF)
    host.got.delete();
  endtask

  task automatic conclude;
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    conclude();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (4) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    apb(1'b0, ccr_pkg::ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b0, ccr_pkg::ADDR_SERIAL, 32'h0);
    `CHK(rd, P_SER)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, ccr_pkg::ADDR_SERIAL, 32'h00005678);
    repeat (8) @(posedge clock_in);
    `CHK(fw, 1'b1)
    host.send($sformatf("zcal%cx", ccr_pkg::CH_UB));
    expect_reply("zBaU");
    `CHK(starts, 1)
    apb(1'b0, ccr_pkg::ADDR_DARK, 32'h0);
    `CHK(rd, 32'h0000abcd)
    lock_sw <= 1'b1;
    repeat (8) @(posedge clock_in);
    `CHK(fw, 1'b0)
    host.send($sformatf("zcal%cx", ccr_pkg::CH_UB));
    expect_reply("zBaL");
    `CHK(starts, 1)
    apb(1'b0, ccr_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[1:0], 2'b11)
    meas <= 32'h00001111;
    lock_sw <= 1'b0;
    repeat (8) @(posedge clock_in);
    `CHK(starts, 2)
    apb(1'b0, ccr_pkg::ADDR_DARK, 32'h0);
    `CHK(rd, 32'h00001111)
    lock_sw <= 1'b1;
    host.send($sformatf("zcal%cx", ccr_pkg::CH_UB));
    expect_reply("zBaL");
    host.send($sformatf("zcal%cx", ccr_pkg::CH_UD));
    expect_reply("zxdL");
    lock_sw <= 1'b0;
    repeat (8) @(posedge clock_in);
    `CHK(starts, 2)
    slow <= 1'b1;
    host.send($sformatf("%cx", ccr_pkg::CH_I));
    expect_reply($sformatf("i,%08h,%08h,%08h,%08h", P_PROTO, P_MODEL,
      P_FEAT, 32'h00005678));
    host.send("zcal500000017.60mx");
    expect_reply("z,5,00000017.60m");
    host.send("zcal600000019.04x");
    expect_reply("z,6,019.0C");
    apb(1'b0, ccr_pkg::ADDR_TEMP, 32'h0);
    `CHK(rd[15:0], 16'h0190)
    host.send("zcalQx");
    repeat (20) @(posedge clock_in);
    `CHK(host.got.size(), 0)
    host.send($sformatf("zcal%cx", ccr_pkg::CH_UD));
    expect_reply("zxdU");
    apb(1'b1, ccr_pkg::ADDR_CTRL, 32'h0);
    repeat (2) @(posedge clock_in);
    `CHK(rx_ready, 1'b0)
    apb(1'b1, ccr_pkg::ADDR_CTRL, 32'h1);
    conclude();
  end
endmodule // ccr_responder_tb
`default_nettype wire

// *** verilog/ccr_pkg.sv ***
// Constants, types and layouts of the calibration command responder
//
// Contract
// - Dark arm command arms dark calibration, replies
// - Armed plus lock switch transition starts calibration
// - Dark reply columns: z, B, a, lock
// - Locked defers calibration, blocks firmware upgrade
// - Unlocked calibrates at once, permits upgrade
// - Arm and disarm replies end CR LF
// - Disarm clears every armed calibration mode
// - Disarm reply columns: z, x, d, lock
// - Info reply: i, protocol revision columns 2-9
// - Info reply: model code columns 11-18
// - Info reply: feature revision columns 20-27
// - Info reply: serial 29-36, CR LF 37-38
// - Offset reply: z,5, twelve chars, CR LF
// - Temperature command stores new calibration temperature
// - Temperature kept raw at own resolution
// - Temperature reply: z,6, six chars, CR LF
`default_nettype none
package ccr_pkg;

  // ==========================================================
  // Characters
  localparam logic [7:0] CH_X = 8'h78;
  localparam logic [7:0] CH_Z = 8'h7a;
  localparam logic [7:0] CH_C = 8'h63;
  localparam logic [7:0] CH_A = 8'h61;
  localparam logic [7:0] CH_L = 8'h6c;
  localparam logic [7:0] CH_I = 8'h69;
  localparam logic [7:0] CH_UB = 8'h42;
  localparam logic [7:0] CH_UD = 8'h44;
  localparam logic [7:0] CH_D = 8'h64;
  localparam logic [7:0] CH_LOCK = 8'h4c;
  localparam logic [7:0] CH_UNLOCK = 8'h55;
  localparam logic [7:0] CH_5 = 8'h35;
  localparam logic [7:0] CH_6 = 8'h36;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_DEGC = 8'h43;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [3:0] DIGIT_HI = 4'h3;

  // ==========================================================
  // Command layout
  localparam int CMD_MAX = 17;
  localparam logic [4:0] LEN_INFO_CMD = 5'h01;
  localparam logic [4:0] LEN_ARM_CMD = 5'h05;
  localparam logic [4:0] LEN_TEMP_CMD = 5'h10;
  localparam logic [4:0] LEN_OFFS_CMD = 5'h11;
  localparam int POS_SEL = 4;
  localparam int POS_VAL = 5;
  localparam int OFFS_CHARS = 12;
  localparam int POS_TEMP_D2 = 10;
  localparam int POS_TEMP_F = 14;

  // ==========================================================
  // Response columns and lengths
  localparam logic [5:0] LEN_ARM = 6'h06;
  localparam logic [5:0] LEN_INFO = 6'h27;
  localparam logic [5:0] LEN_OFFS = 6'h12;
  localparam logic [5:0] LEN_TEMP = 6'h0c;
  localparam logic [5:0] COL_PROTO = 6'h02;
  localparam logic [5:0] COL_MODEL = 6'h0b;
  localparam logic [5:0] COL_FEAT = 6'h14;
  localparam logic [5:0] COL_SERIAL = 6'h1d;
  localparam logic [5:0] COL_VAL = 6'h04;
  localparam logic [5:0] FIELD8 = 6'h08;
  localparam logic [5:0] COL_1 = 6'h01;
  localparam logic [5:0] COL_2 = 6'h02;
  localparam logic [5:0] COL_3 = 6'h03;
  localparam logic [5:0] COL_T_DOT = 6'h07;
  localparam logic [5:0] COL_T_FRAC = 6'h08;
  localparam logic [5:0] COL_T_C = 6'h09;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SERIAL = 8'h08;
  localparam logic [7:0] ADDR_TEMP = 8'h0c;
  localparam logic [7:0] ADDR_DARK = 8'h10;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [15:0] TEMP_RST = 16'h0000;

  // ==========================================================
  // Types
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ccr_byte_s;

  typedef enum logic [1:0] {
    ST_COLLECT = 2'b00,
    ST_EXEC = 2'b01,
    ST_SEND = 2'b10
  } ccr_state_e;

  typedef enum logic [2:0] {
    RK_NONE = 3'b000,
    RK_ARM = 3'b001,
    RK_DISARM = 3'b010,
    RK_INFO = 3'b011,
    RK_OFFS = 3'b100,
    RK_TEMP = 3'b101
  } ccr_kind_e;

endpackage
`default_nettype wire

// *** verilog/ccr_responder.sv ***
// Calibration command responder: byte link parser, replies, APB registers
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none

module ccr_responder #(
  parameter logic [31:0] PROTO_REV = 32'h00000007, // Arbitrary value
  parameter logic [31:0] MODEL_CODE = 32'h00000042, // Arbitrary value
  parameter logic [31:0] FEATURE_REV = 32'h00000009, // Arbitrary value
  parameter logic [31:0] SERIAL_RST = 32'h00001234, // Arbitrary value
  parameter int DARK_W = 32
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Host byte link
  input wire ccr_pkg::ccr_byte_s rx_in,
  output logic rx_ready_out,
  output ccr_pkg::ccr_byte_s tx_out,
  input wire logic tx_ready_in,
  // Lock switch and calibration
  input wire logic lock_sw_in,
  input wire logic [DARK_W-1:0] dark_meas_in,
  output logic dark_cal_start_out,
  output logic fw_upgrade_en_out,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] bcd_char(input logic [31:0] v,
                                          input logic [5:0] k);
    logic [2:0] n;
    n = 3'(3'h7 - k[2:0]);
    bcd_char = {ccr_pkg::DIGIT_HI, v[n*4 +: 4]};
  endfunction
  function automatic logic in_field(input logic [5:0] i,
                                    input logic [5:0] s,
                                    input logic [5:0] w);
    in_field = (i >= s) && (i < 6'(s + w));
  endfunction
  function automatic logic [7:0] resp_byte(
    input ccr_pkg::ccr_kind_e kind,
    input logic [5:0] i,
    input logic [5:0] len,
    input logic lk,
    input logic [31:0] serial,
    input logic [95:0] offs,
    input logic [15:0] temp);
    logic [5:0] d;
    logic [3:0] oi;
    resp_byte = ccr_pkg::CH_COMMA;
    d = 6'h00;
    oi = 4'h0;
    if (i == 6'(len - 6'h02)) begin
      resp_byte = ccr_pkg::CH_CR;
    end else if (i == 6'(len - 6'h01)) begin
      resp_byte = ccr_pkg::CH_LF;
    end else if (i == 6'h00) begin
      resp_byte = (kind == ccr_pkg::RK_INFO) ? ccr_pkg::CH_I
                                             : ccr_pkg::CH_Z;
    end else begin
      case (kind)
        ccr_pkg::RK_ARM, ccr_pkg::RK_DISARM: begin
          if (i == ccr_pkg::COL_1) begin
            resp_byte = (kind == ccr_pkg::RK_ARM) ? ccr_pkg::CH_UB
                                                  : ccr_pkg::CH_X;
          end else if (i == ccr_pkg::COL_2) begin
            resp_byte = (kind == ccr_pkg::RK_ARM) ? ccr_pkg::CH_A
                                                  : ccr_pkg::CH_D;
          end else begin
            resp_byte = lk ? ccr_pkg::CH_LOCK
                           : ccr_pkg::CH_UNLOCK;
          end
        end
        ccr_pkg::RK_INFO: begin
          if (in_field(i, ccr_pkg::COL_PROTO, ccr_pkg::FIELD8)) begin
            d = 6'(i - ccr_pkg::COL_PROTO);
            resp_byte = bcd_char(PROTO_REV, d);
          end else if (in_field(i, ccr_pkg::COL_MODEL, ccr_pkg::FIELD8)) begin
            d = 6'(i - ccr_pkg::COL_MODEL);
            resp_byte = bcd_char(MODEL_CODE, d);
          end else if (in_field(i, ccr_pkg::COL_FEAT, ccr_pkg::FIELD8)) begin
            d = 6'(i - ccr_pkg::COL_FEAT);
            resp_byte = bcd_char(FEATURE_REV, d);
          end else if (in_field(i, ccr_pkg::COL_SERIAL,
                                ccr_pkg::FIELD8)) begin
            d = 6'(i - ccr_pkg::COL_SERIAL);
            resp_byte = bcd_char(serial, d);
          end
        end
        ccr_pkg::RK_OFFS: begin
          if (i == ccr_pkg::COL_2) begin
            resp_byte = ccr_pkg::CH_5;
          end else if (i >= ccr_pkg::COL_VAL) begin
            d = 6'(i - ccr_pkg::COL_VAL);
            oi = 4'(ccr_pkg::OFFS_CHARS - 1 - d);
            resp_byte = offs[oi*8 +: 8];
          end
        end
        ccr_pkg::RK_TEMP: begin
          if (i == ccr_pkg::COL_2) begin
            resp_byte = ccr_pkg::CH_6;
          end else if (in_field(i, ccr_pkg::COL_VAL, ccr_pkg::COL_3)) begin
            d = 6'(i - ccr_pkg::COL_VAL);
            oi = 4'(4'd3 - d[3:0]);
            resp_byte = {ccr_pkg::DIGIT_HI, temp[oi*4 +: 4]};
          end else if (i == ccr_pkg::COL_T_DOT) begin
            resp_byte = ccr_pkg::CH_DOT;
          end else if (i == ccr_pkg::COL_T_FRAC) begin
            resp_byte = {ccr_pkg::DIGIT_HI, temp[3:0]};
          end else if (i == ccr_pkg::COL_T_C) begin
            resp_byte = ccr_pkg::CH_DEGC;
          end
        end
        default: resp_byte = ccr_pkg::CH_COMMA;
      endcase
    end
  endfunction

  // ==========================================================
  // Lock switch synchroniser
  logic lock_meta, lock_sync, lock_prev;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      lock_prev <= 1'b0;
    end else begin
      lock_meta <= lock_sw_in;
      lock_sync <= lock_meta;
      lock_prev <= lock_sync;
    end
  end
  wire logic locked = lock_sync;
  wire logic lock_edge = lock_sync ^ lock_prev;

  // ==========================================================
  // Registers and state
  logic ctrl_en;
  logic [31:0] serial_num;
  logic [15:0] temp_raw;
  logic [95:0] offs_val;
  logic [DARK_W-1:0] dark_cal;
  logic dark_armed;
  ccr_pkg::ccr_state_e state, next_state;
  ccr_pkg::ccr_kind_e kind, next_kind;
  logic [7:0] cmd [0:ccr_pkg::CMD_MAX-1];
  logic [4:0] cmd_cnt;
  logic [5:0] idx, resp_len, next_len;
  logic skid_v;
  logic [7:0] skid_d;
  wire logic rx_take = rx_in.valid && rx_ready_out;
  wire logic rx_term = rx_take && (rx_in.data == ccr_pkg::CH_X);
  wire logic buf_ready = !skid_v;
  wire logic push = (state == ccr_pkg::ST_SEND) && buf_ready;
  wire logic [7:0] push_d = resp_byte(kind, idx, resp_len, locked,
                                      serial_num, offs_val, temp_raw);
  wire logic zcal = (cmd[0] == ccr_pkg::CH_Z) && (cmd[1] == ccr_pkg::CH_C)
                    && (cmd[2] == ccr_pkg::CH_A) && (cmd[3] == ccr_pkg::CH_L);

  // ==========================================================
  // Command decode at the terminator
  always_comb begin
    next_kind = ccr_pkg::RK_NONE;
    next_len = ccr_pkg::LEN_ARM;
    if (cmd_cnt == ccr_pkg::LEN_INFO_CMD && cmd[0] == ccr_pkg::CH_I) begin
      next_kind = ccr_pkg::RK_INFO;
      next_len = ccr_pkg::LEN_INFO;
    end else if (zcal && cmd_cnt == ccr_pkg::LEN_ARM_CMD &&
                 cmd[ccr_pkg::POS_SEL] == ccr_pkg::CH_UB) begin
      next_kind = ccr_pkg::RK_ARM;
    end else if (zcal && cmd_cnt == ccr_pkg::LEN_ARM_CMD &&
                 cmd[ccr_pkg::POS_SEL] == ccr_pkg::CH_UD) begin
      next_kind = ccr_pkg::RK_DISARM;
    end else if (zcal && cmd_cnt == ccr_pkg::LEN_OFFS_CMD &&
                 cmd[ccr_pkg::POS_SEL] == ccr_pkg::CH_5) begin
      next_kind = ccr_pkg::RK_OFFS;
      next_len = ccr_pkg::LEN_OFFS;
    end else if (zcal && cmd_cnt == ccr_pkg::LEN_TEMP_CMD &&
                 cmd[ccr_pkg::POS_SEL] == ccr_pkg::CH_6) begin
      next_kind = ccr_pkg::RK_TEMP;
      next_len = ccr_pkg::LEN_TEMP;
    end
  end
  always_comb begin
    next_state = state;
    case (state)
      ccr_pkg::ST_COLLECT: if (rx_term) next_state = ccr_pkg::ST_EXEC;
      ccr_pkg::ST_EXEC: begin
        next_state = (next_kind == ccr_pkg::RK_NONE) ? ccr_pkg::ST_COLLECT
                                                     : ccr_pkg::ST_SEND;
      end
      ccr_pkg::ST_SEND: begin
        if (push && idx == 6'(resp_len - 6'h01)) begin
          next_state = ccr_pkg::ST_COLLECT;
        end
      end
      default: next_state = ccr_pkg::ST_COLLECT;
    endcase
  end

  // ==========================================================
  // Parser and reply sequencer
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ccr_pkg::ST_COLLECT;
      kind <= ccr_pkg::RK_NONE;
      cmd_cnt <= 5'h00;
      idx <= 6'h00;
      resp_len <= ccr_pkg::LEN_ARM;
      rx_ready_out <= 1'b0;
    end else begin
      state <= next_state;
      // No byte taken while executing or replying
      rx_ready_out <= (next_state == ccr_pkg::ST_COLLECT) && ctrl_en;
      if (state == ccr_pkg::ST_EXEC) begin
        kind <= next_kind;
        resp_len <= next_len;
        idx <= 6'h00;
        cmd_cnt <= 5'h00;
      end else if (push) begin
        idx <= 6'(idx + 6'h01);
      end
      if (rx_take && !rx_term && cmd_cnt < 5'(ccr_pkg::CMD_MAX)) begin
        cmd_cnt <= 5'(cmd_cnt + 5'h01);
      end
    end
  end
  // Overlong commands stop filling at CMD_MAX bytes; one starting zcal5 still matches as an offset command on the terminator
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int k = 0; k < ccr_pkg::CMD_MAX; k++) cmd[k] <= 8'h00;
    end else if (rx_take && !rx_term &&
                 cmd_cnt < 5'(ccr_pkg::CMD_MAX)) begin
      cmd[cmd_cnt] <= rx_in.data;
    end
  end

  // ==========================================================
  // Dark calibration arming
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dark_armed <= 1'b0;
      dark_cal_start_out <= 1'b0;
      dark_cal <= '0;
    end else begin
      dark_cal_start_out <= 1'b0;
      if (state == ccr_pkg::ST_EXEC && next_kind == ccr_pkg::RK_ARM) begin
        if (locked) begin
          dark_armed <= 1'b1;
        end else begin
          dark_cal_start_out <= 1'b1;
          dark_cal <= dark_meas_in;
          dark_armed <= 1'b0;
        end
      end else if (state == ccr_pkg::ST_EXEC &&
                   next_kind == ccr_pkg::RK_DISARM) begin
        dark_armed <= 1'b0;
      end else if (dark_armed && lock_edge) begin
        dark_cal_start_out <= 1'b1;
        dark_cal <= dark_meas_in;
        dark_armed <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fw_upgrade_en_out <= 1'b0;
    end else begin
      fw_upgrade_en_out <= !locked;
    end
  end

  // ==========================================================
  // Manually set values
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      offs_val <= '0;
      temp_raw <= ccr_pkg::TEMP_RST;
    end else if (state == ccr_pkg::ST_EXEC) begin
      if (next_kind == ccr_pkg::RK_OFFS) begin
        for (int k = 0; k < ccr_pkg::OFFS_CHARS; k++) begin
          offs_val[(ccr_pkg::OFFS_CHARS-1-k)*8 +: 8] <=
            cmd[ccr_pkg::POS_VAL+k];
        end
      end
      if (next_kind == ccr_pkg::RK_TEMP) begin
        // Tenths kept, hundredths dropped: echo can differ from input
        temp_raw <= {cmd[ccr_pkg::POS_TEMP_D2][3:0],
                     cmd[ccr_pkg::POS_TEMP_D2+1][3:0],
                     cmd[ccr_pkg::POS_TEMP_D2+2][3:0],
                     cmd[ccr_pkg::POS_TEMP_F][3:0]};
      end
    end
  end

  // ==========================================================
  // Two-entry output buffer: output stage plus skid entry
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_out <= '0;
      skid_v <= 1'b0;
      skid_d <= 8'h00;
    end else if (!tx_out.valid || tx_ready_in) begin
      if (skid_v) begin
        tx_out <= {1'b1, skid_d};
        skid_v <= 1'b0;
      end else begin
        tx_out <= {push, push_d};
      end
    end else if (push) begin
      skid_v <= 1'b1;
      skid_d <= push_d;
    end
  end

  // ==========================================================
  // APB slave: no wait states, ready in the first access cycle
  wire logic apb_setup = psel_in && !penable_in;
  wire logic apb_wr = psel_in && penable_in && pready_out && pwrite_in;
  wire logic addr_ok = (paddr_in <= ccr_pkg::ADDR_DARK) &&
                       (paddr_in[1:0] == 2'b00);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr_in)
      ccr_pkg::ADDR_CTRL: rd_mux = {31'h0, ctrl_en};
      ccr_pkg::ADDR_STATUS: rd_mux = {29'h0, state != ccr_pkg::ST_COLLECT,
                                      locked, dark_armed};
      ccr_pkg::ADDR_SERIAL: rd_mux = serial_num;
      ccr_pkg::ADDR_TEMP: rd_mux = {16'h0, temp_raw};
      ccr_pkg::ADDR_DARK: rd_mux = 32'(dark_cal);
      default: rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else begin
      pready_out <= apb_setup;
      pslverr_out <= apb_setup && !addr_ok;
      prdata_out <= (apb_setup && !pwrite_in) ? rd_mux : 32'h00000000;
    end
  end
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_en <= ccr_pkg::CTRL_EN_RST;
      serial_num <= SERIAL_RST;
    end else if (apb_wr) begin
      if (paddr_in == ccr_pkg::ADDR_CTRL) ctrl_en <= pwdata_in[0];
      if (paddr_in == ccr_pkg::ADDR_SERIAL) serial_num <= pwdata_in;
    end
  end

endmodule // ccr_responder

`default_nettype wire
